/* File: src/mao_pkg.sv */
// constants and types for the math accelerator operand register logic
package mao_pkg;
  // register offsets on the special-function register bus
  localparam logic [7:0] MAO_ADDR_OPERAND_A = 8'hD3;
  localparam logic [7:0] MAO_ADDR_OPERAND_B = 8'hD4;
  localparam logic [7:0] MAO_ADDR_CONTROL_ONE = 8'hD1;
  // control register field positions
  localparam int MAO_BIT_BUSY = 7;
  localparam int MAO_BIT_CLEAR = 4;
  // reset values and the value read once a result is exhausted
  localparam logic [31:0] MAO_RST_OPERAND_A = 32'h0000_0000;
  localparam logic [15:0] MAO_RST_OPERAND_B = 16'h0000;
  localparam logic [7:0] MAO_RST_RDATA = 8'h00;
  localparam logic [7:0] MAO_EXHAUSTED_READ = 8'h00;
  // byte counts of the operand words
  localparam logic [2:0] MAO_A_BYTES = 3'h4;
  localparam logic [2:0] MAO_A_HALF_BYTES = 3'h2;
  localparam logic [1:0] MAO_B_BYTES = 2'h2;
  // divide step counts
  localparam logic [5:0] MAO_DIV32_STEPS = 6'h20;
  localparam logic [5:0] MAO_DIV16_STEPS = 6'h10;

  typedef enum logic [1:0] {
    MAO_MODE_NONE,
    MAO_MODE_MUL16,
    MAO_MODE_DIV16,
    MAO_MODE_DIV32
  } mao_mode_e;

  typedef enum logic [1:0] {
    MAO_ST_IDLE,
    MAO_ST_LOAD,
    MAO_ST_DIVIDE
  } mao_state_e;
endpackage

/* File: src/mao_operand_regs.sv */
// operand and result registers of the math accelerator with byte pointers
// Operation
// - clear bit zeros operands, accumulator, then self-clears
// - writing zero to clear bit does nothing
// - operand a takes 32 or 16-bit numerator
// - operand a takes second multiply operand
// - operand a reads quotient or product after completion
// - reset, done, clear, busy reinitialise both pointers
// - each operand a read advances one byte
// - each operand a write fills next byte
// - operand a pointers lock, never wrap
// - operand a reads 00h once result exhausted
// - reset, clear, busy set zero operand a
// - operand b takes 16-bit denominator in divides
// - operand b takes first multiply operand
// - operand b reads 16-bit remainder after divide
// - operand b reads high, low, then 00h
// - operand b write pointer moves low to high, locks
// - operand b reads 00h after reset, initialisation
// - busy sets on first load, clears when done
module mao_operand_regs
  import mao_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // special-function register bus from the core
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // operating mode from the mode field
  input wire mao_mode_e accel_mode,
  // status and side effects
  output logic accel_busy_flag,
  output logic accumulator_clear,
  output logic calc_done
);

  logic [31:0] operand_a_ff;
  logic [15:0] operand_b_ff;
  logic [16:0] rem_ff;
  logic [5:0] step_ff;
  logic [2:0] a_wr_cnt_ff;
  logic [2:0] a_rd_left_ff;
  logic [1:0] b_wr_cnt_ff;
  logic [1:0] b_rd_left_ff;
  logic clear_all_operands_ff;
  logic [7:0] sfr_rdata_ff;
  logic accumulator_clear_ff;
  logic calc_done_ff;
  mao_state_e state_ff;
  mao_state_e nxt_state;

  logic wr_a;
  logic wr_b;
  logic rd_a;
  logic rd_b;
  logic wr_ctrl;
  logic clear_req;
  logic soft_init;
  logic load_start;
  logic init_all;
  logic a_ready;
  logic b_full_next;
  logic a_full_next;
  logic start_calc;
  logic mul_mode;
  logic [2:0] a_need;
  logic [16:0] rem_shift;
  logic rem_ge;
  logic div_last;
  logic [31:0] product;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  logic [1:0] a_rd_byte;

  assign wr_a = sfr_wr && (sfr_addr == MAO_ADDR_OPERAND_A);
  assign wr_b = sfr_wr && (sfr_addr == MAO_ADDR_OPERAND_B);
  assign rd_a = sfr_rd && (sfr_addr == MAO_ADDR_OPERAND_A);
  assign rd_b = sfr_rd && (sfr_addr == MAO_ADDR_OPERAND_B);
  assign wr_ctrl = sfr_wr && (sfr_addr == MAO_ADDR_CONTROL_ONE);
  // only a written one acts; a written zero is no operation
  assign clear_req = wr_ctrl && sfr_wdata[MAO_BIT_CLEAR];
  // software clearing the busy flag mid-task re-initialises the engine
  assign soft_init = wr_ctrl && !sfr_wdata[MAO_BIT_BUSY] && (state_ff != MAO_ST_IDLE);
  // a load while idle or computing starts a fresh task and drops old results
  assign load_start = (wr_a || wr_b) && (state_ff != MAO_ST_LOAD);
  assign init_all = clear_req || soft_init || load_start;

  assign mul_mode = (accel_mode == MAO_MODE_MUL16);
  assign a_need = (accel_mode == MAO_MODE_DIV32) ? MAO_A_BYTES : MAO_A_HALF_BYTES;
  // byte counts after the current write, counted from a fresh start on load_start
  assign a_full_next = wr_a ? (((load_start ? 3'h0 : a_wr_cnt_ff) + 3'h1) >= a_need)
                            : (!load_start && (a_wr_cnt_ff >= a_need));
  assign b_full_next = wr_b ? ((load_start ? 2'h0 : b_wr_cnt_ff) == 2'h1)
                            : (!load_start && (b_wr_cnt_ff == MAO_B_BYTES));
  assign a_ready = a_full_next;
  // multiply loads b then a; divides load a then b; the last write starts work
  assign start_calc = (accel_mode != MAO_MODE_NONE) && !clear_req && !soft_init &&
                      (wr_a || wr_b) && a_ready && b_full_next;

  // the byte that completes the operands is still on the bus, so take it from there
  assign mul_a = wr_a ? {sfr_wdata, operand_a_ff[7:0]} : operand_a_ff[15:0];
  assign mul_b = wr_b ? {sfr_wdata, operand_b_ff[7:0]} : operand_b_ff;
  assign product = mul_a * mul_b;
  // byte index kept at two bits so the step below the bottom byte wraps to 3 and stays inside the word
  assign a_rd_byte = 2'(a_rd_left_ff[1:0] - 2'h1);
  assign rem_shift = {rem_ff[15:0], operand_a_ff[31]};
  assign rem_ge = rem_shift >= {1'b0, operand_b_ff};
  assign div_last = (step_ff == 6'h01);

  // task sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MAO_ST_IDLE: begin
        if (wr_a || wr_b) begin
          nxt_state = MAO_ST_LOAD;
        end
      end
      MAO_ST_LOAD: begin
        if (start_calc && !mul_mode) begin
          nxt_state = MAO_ST_DIVIDE;
        end else if (start_calc) begin
          nxt_state = MAO_ST_IDLE;
        end
      end
      MAO_ST_DIVIDE: begin
        if (div_last) begin
          nxt_state = MAO_ST_IDLE;
        end
      end
      default: begin
        nxt_state = MAO_ST_IDLE;
      end
    endcase
    if (clear_req || soft_init) begin
      nxt_state = MAO_ST_IDLE;
    end else if (load_start) begin
      nxt_state = start_calc ? (mul_mode ? MAO_ST_IDLE : MAO_ST_DIVIDE) : MAO_ST_LOAD;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= MAO_ST_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // clear bit: reads one for the cycle of clearing, then drops by itself
  always_ff @(posedge clk) begin
    if (reset) begin
      clear_all_operands_ff <= 1'b0;
      accumulator_clear_ff <= 1'b0;
    end else if (clk_en) begin
      clear_all_operands_ff <= clear_req;
      accumulator_clear_ff <= clear_req;
    end
  end

  // operand a storage, multiply result and divide quotient
  always_ff @(posedge clk) begin
    if (reset) begin
      operand_a_ff <= MAO_RST_OPERAND_A;
    end else if (clk_en) begin
      if (clear_req || soft_init) begin
        operand_a_ff <= MAO_RST_OPERAND_A;
      end else if (start_calc && mul_mode) begin
        operand_a_ff <= product;
      end else if (wr_a) begin
        // write pointer locks at the top byte, extra writes are dropped
        if (load_start) begin
          operand_a_ff <= {24'h000000, sfr_wdata};
        end else if (a_wr_cnt_ff < MAO_A_BYTES) begin
          operand_a_ff[a_wr_cnt_ff[1:0] * 8 +: 8] <= sfr_wdata;
        end
      end else if (state_ff == MAO_ST_DIVIDE) begin
        operand_a_ff <= {operand_a_ff[30:0], rem_ge};
      end else if (load_start) begin
        operand_a_ff <= MAO_RST_OPERAND_A;
      end else if (start_calc && (accel_mode == MAO_MODE_DIV16)) begin
        // left-align a 16-bit numerator so both divides shift from bit 31
        operand_a_ff <= {operand_a_ff[15:0], 16'h0000};
      end
    end
  end

  // operand b storage, divisor and remainder
  always_ff @(posedge clk) begin
    if (reset) begin
      operand_b_ff <= MAO_RST_OPERAND_B;
    end else if (clk_en) begin
      if (clear_req || soft_init) begin
        operand_b_ff <= MAO_RST_OPERAND_B;
      end else if (start_calc && mul_mode) begin
        operand_b_ff <= MAO_RST_OPERAND_B;
      end else if (wr_b) begin
        if (load_start) begin
          operand_b_ff <= {8'h00, sfr_wdata};
        end else if (b_wr_cnt_ff == 2'h1) begin
          operand_b_ff[15:8] <= sfr_wdata;
        end else if (b_wr_cnt_ff == 2'h0) begin
          operand_b_ff[7:0] <= sfr_wdata;
        end
      end else if (load_start) begin
        operand_b_ff <= MAO_RST_OPERAND_B;
      end else if ((state_ff == MAO_ST_DIVIDE) && div_last) begin
        operand_b_ff <= rem_ge ? 16'(rem_shift - {1'b0, operand_b_ff})
                               : rem_shift[15:0];
      end
    end
  end

  // partial remainder and step counter of the restoring divider
  always_ff @(posedge clk) begin
    if (reset) begin
      rem_ff <= 17'h00000;
      step_ff <= 6'h00;
    end else if (clk_en) begin
      if (start_calc && !mul_mode) begin
        rem_ff <= 17'h00000;
        step_ff <= (accel_mode == MAO_MODE_DIV32) ? MAO_DIV32_STEPS : MAO_DIV16_STEPS;
      end else if (state_ff == MAO_ST_DIVIDE) begin
        rem_ff <= rem_ge ? (rem_shift - {1'b0, operand_b_ff}) : rem_shift;
        step_ff <= step_ff - 6'h01;
      end
    end
  end

  // write pointers, reset to the low byte on every reinitialising event
  always_ff @(posedge clk) begin
    if (reset) begin
      a_wr_cnt_ff <= 3'h0;
      b_wr_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      if (clear_req || soft_init || start_calc || (state_ff == MAO_ST_DIVIDE)) begin
        a_wr_cnt_ff <= 3'h0;
        b_wr_cnt_ff <= 2'h0;
      end else if (load_start) begin
        a_wr_cnt_ff <= wr_a ? 3'h1 : 3'h0;
        b_wr_cnt_ff <= wr_b ? 2'h1 : 2'h0;
      end else begin
        if (wr_a && (a_wr_cnt_ff < MAO_A_BYTES)) begin
          a_wr_cnt_ff <= a_wr_cnt_ff + 3'h1;
        end
        if (wr_b && (b_wr_cnt_ff < MAO_B_BYTES)) begin
          b_wr_cnt_ff <= b_wr_cnt_ff + 2'h1;
        end
      end
    end
  end

  // read pointers count bytes left, starting from the most significant byte
  always_ff @(posedge clk) begin
    if (reset) begin
      a_rd_left_ff <= MAO_A_BYTES;
      b_rd_left_ff <= MAO_B_BYTES;
    end else if (clk_en) begin
      if (clear_req || soft_init || load_start || (start_calc && mul_mode)) begin
        a_rd_left_ff <= MAO_A_BYTES;
        b_rd_left_ff <= MAO_B_BYTES;
      end else if ((state_ff == MAO_ST_DIVIDE) && div_last) begin
        // a 16-bit quotient is read in two bytes
        a_rd_left_ff <= (accel_mode == MAO_MODE_DIV16) ? MAO_A_HALF_BYTES : MAO_A_BYTES;
        b_rd_left_ff <= MAO_B_BYTES;
      end else begin
        if (rd_a && (a_rd_left_ff != 3'h0)) begin
          a_rd_left_ff <= a_rd_left_ff - 3'h1;
        end
        if (rd_b && (b_rd_left_ff != 2'h0)) begin
          b_rd_left_ff <= b_rd_left_ff - 2'h1;
        end
      end
    end
  end

  // read data, registered one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata_ff <= MAO_RST_RDATA;
    end else if (clk_en && sfr_rd) begin
      if (rd_a) begin
        sfr_rdata_ff <= (a_rd_left_ff == 3'h0) ? MAO_EXHAUSTED_READ
                        : operand_a_ff[{a_rd_byte, 3'h0} +: 8];
      end else if (rd_b) begin
        sfr_rdata_ff <= (b_rd_left_ff == 2'h0) ? MAO_EXHAUSTED_READ
                        : operand_b_ff[(b_rd_left_ff[0] ? 0 : 8) +: 8];
      end else if (sfr_addr == MAO_ADDR_CONTROL_ONE) begin
        sfr_rdata_ff <= {accel_busy_flag, 2'b00, clear_all_operands_ff, 4'h0};
      end else begin
        sfr_rdata_ff <= MAO_RST_RDATA;
      end
    end
  end

  // completion pulse, feeds the accumulator adder outside
  always_ff @(posedge clk) begin
    if (reset) begin
      calc_done_ff <= 1'b0;
    end else if (clk_en) begin
      calc_done_ff <= (start_calc && mul_mode) ||
                      ((state_ff == MAO_ST_DIVIDE) && div_last && !init_all);
    end
  end

  assign accel_busy_flag = (state_ff != MAO_ST_IDLE);
  assign accumulator_clear = accumulator_clear_ff;
  assign calc_done = calc_done_ff;
  assign sfr_rdata = sfr_rdata_ff;

endmodule

/* File: bench/mao_operand_regs_asserts.sv */
// port assertions for the operand register block
module mao_operand_regs_asserts
  import mao_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // mode and status
  input wire mao_mode_e accel_mode,
  input wire logic accel_busy_flag,
  input wire logic accumulator_clear,
  input wire logic calc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence clr_wr;
    clk_en && sfr_wr && sfr_addr == MAO_ADDR_CONTROL_ONE && sfr_wdata[MAO_BIT_CLEAR];
  endsequence
  sequence ctl_zero_wr;
    clk_en && sfr_wr && sfr_addr == MAO_ADDR_CONTROL_ONE && !sfr_wdata[MAO_BIT_CLEAR];
  endsequence
  sequence a_first;
    clk_en && sfr_wr && sfr_addr == MAO_ADDR_OPERAND_A && !accel_busy_flag;
  endsequence
  clear_pulse_a: assert property (clr_wr |=> accumulator_clear ##1 !accumulator_clear)
    else $error("clear pulse shape wrong");
  clear_idles_a: assert property (clr_wr |=> !accel_busy_flag)
    else $error("busy survived a clear");
  zero_write_a: assert property (ctl_zero_wr ##0 accel_busy_flag && sfr_wdata[MAO_BIT_BUSY]
    |=> accel_busy_flag && !accumulator_clear)
    else $error("zero clear bit had an effect");
  load_busy_a: assert property (a_first ##0 accel_mode != MAO_MODE_NONE |=> accel_busy_flag)
    else $error("busy not set on load");
  done_idle_a: assert property ($rose(calc_done) |-> !accel_busy_flag && $past(accel_busy_flag))
    else $error("done without busy falling");
  busy_bound_a: assert property ($rose(accel_busy_flag) |-> ##[1:100] !accel_busy_flag)
    else $error("busy stuck");
  rdata_hold_a: assert property (!(clk_en && sfr_rd) |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  reset_state_a: assert property ($fell(reset) |-> sfr_rdata == MAO_RST_RDATA
    && !accel_busy_flag && !calc_done && !accumulator_clear)
    else $error("reset state wrong");
endmodule

bind mao_operand_regs mao_operand_regs_asserts u_chk (.clk(clk), .reset(reset),
  .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .accel_mode(accel_mode),
  .accel_busy_flag(accel_busy_flag), .accumulator_clear(accumulator_clear),
  .calc_done(calc_done));

/* File: bench/mao_core_model.sv */
// core-side model issuing byte reads and writes on the register bus
module mao_core_model (
  // clock
  input wire logic clk,
  // register bus
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    // stale data must not look valid
    sfr_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the operand register block
module testbench;
  import mao_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, clk_en, sfr_wr, sfr_rd, busy, clr_p, done;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [31:0] a;
  mao_mode_e mode, m;
  int mismatches, n_tests, cyc;
  mao_operand_regs uut (.clk(clk), .reset(reset), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .accel_mode(mode), .accel_busy_flag(busy), .accumulator_clear(clr_p), .calc_done(done));
  mao_core_model core (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] res(mao_mode_e md, logic [31:0] x, logic [15:0] y, bit rem);
    if (md == MAO_MODE_MUL16)
      return rem ? 32'h0 : x[15:0] * y;
    return rem ? x % y : x / y;
  endfunction
  task automatic rd_word(input logic [7:0] ad, input logic [31:0] e, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      core.rd(ad, d);
      check(d, e[8*i +: 8]);
    end
    core.rd(ad, d);
    check(d, MAO_EXHAUSTED_READ);
  endtask
  task automatic ld(input logic [7:0] ad, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++)
      core.wr(ad, v[8*i +: 8]);
  endtask
  // xa/xd is an extra write slipped between the two operand loads
  task automatic run_op(input mao_mode_e md, input logic [31:0] x, input logic [15:0] y,
    input logic [7:0] xa, input logic [7:0] xd);
    int nb;
    mode <= md;
    nb = (md == MAO_MODE_DIV16) ? 2 : 4;
    if (md == MAO_MODE_MUL16) begin
      ld(MAO_ADDR_OPERAND_B, y, 2);
      core.wr(xa, xd);
      ld(MAO_ADDR_OPERAND_A, x, 2);
    end else begin
      ld(MAO_ADDR_OPERAND_A, x, nb);
      core.wr(xa, xd);
      ld(MAO_ADDR_OPERAND_B, y, 2);
    end
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    for (int i = 0; i < 100 && busy !== 1'b0; i++)
      @(posedge clk);
    check(busy, 1'b0);
    rd_word(MAO_ADDR_OPERAND_A, res(md, x, y, 1'b0), nb);
    rd_word(MAO_ADDR_OPERAND_B, res(md, x, y, 1'b1), 2);
  endtask
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    mode = MAO_MODE_NONE;
    void'($urandom(24));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    core.rd(MAO_ADDR_OPERAND_A, d);
    check(d, 8'h00);
    core.rd(MAO_ADDR_OPERAND_B, d);
    check(d, 8'h00);
    run_op(MAO_MODE_DIV16, 32'h0000_FFFF, 16'h0001, 8'hD0, 8'h5A);
    run_op(MAO_MODE_DIV32, 32'hFFFF_FFFF, 16'hFFFF, MAO_ADDR_OPERAND_A, 8'hA5);
    run_op(MAO_MODE_MUL16, 32'h0000_FFFF, 16'hFFFF, MAO_ADDR_CONTROL_ONE, 8'h80);
    for (int i = 0; i < 24; i++) begin
      m = mao_mode_e'(2'(1 + i % 3));
      a = $urandom();
      if (m != MAO_MODE_DIV32)
        a[31:16] = 16'h0000;
      run_op(m, a, 16'($urandom_range(65535, 1)), 8'hD0, 8'($urandom()));
    end
    // half-loaded multiply, so a missed clear shows in the low bytes
    mode <= MAO_MODE_MUL16;
    ld(MAO_ADDR_OPERAND_B, 32'h0000_5678, 2);
    ld(MAO_ADDR_OPERAND_A, 32'h0000_0034, 1);
    core.wr(MAO_ADDR_CONTROL_ONE, 8'h10);
    core.rd(MAO_ADDR_CONTROL_ONE, d);
    check(d, 8'h00);
    rd_word(MAO_ADDR_OPERAND_A, 32'h0, 4);
    rd_word(MAO_ADDR_OPERAND_B, 32'h0, 2);
    run_op(MAO_MODE_DIV32, 32'h8000_0001, 16'h0003, 8'hD0, 8'h00);
    tally_and_finish();
  end
endmodule
